/* File: core/psc_pkg.sv */
// Package for the pin strap configuration decoder: pin levels, modes and bundles
package psc_pkg;

	// ********************************
	// Resolved three-level pin state
	// ********************************
	typedef enum logic [1:0] {
		PSC_LVL_LOW = 2'h0,
		PSC_LVL_HIGH = 2'h1,
		PSC_LVL_OPEN = 2'h2
	} psc_level_t;

	// Buffer signalling types, shared by inputs and outputs
	typedef enum logic [1:0] {
		PSC_IO_LVDS = 2'h0,
		PSC_IO_HCSL = 2'h1,
		PSC_IO_LVCMOS = 2'h2
	} psc_iotype_t;

	typedef enum logic [1:0] {
		PSC_EDGE_SLOW = 2'h0,
		PSC_EDGE_MEDIUM = 2'h1,
		PSC_EDGE_FAST = 2'h2
	} psc_edge_t;

	// Divider on the secondary clock input
	typedef enum logic [1:0] {
		PSC_DIV_1 = 2'h0,
		PSC_DIV_2 = 2'h1,
		PSC_DIV_4 = 2'h2
	} psc_div_t;

	// Input multiplexer mode
	typedef enum logic [1:0] {
		PSC_SEL_PRIMARY = 2'h0,
		PSC_SEL_SECONDARY = 2'h1,
		PSC_SEL_AUTO = 2'h2
	} psc_sel_t;

	// Loader sequence, Gray coded along the path
	typedef enum logic [1:0] {
		PSC_ST_RESET = 2'h0,
		PSC_ST_SAMPLE = 2'h1,
		PSC_ST_RUN = 2'h3
	} psc_state_t;

	// Drive strength code, one per output type and edge rate
	localparam int PSC_DRIVE_W = 4;
	localparam logic [PSC_DRIVE_W-1:0] PSC_DRIVE_RST = 4'h0;
	localparam int PSC_SYNC_STAGES = 2;
	localparam logic [1:0] PSC_DIV1_CODE = 2'h0;

	// Tri-level pin as sensed: value seen under the pull-up probe plus value seen under the pull-down probe
	typedef struct packed {
		logic pull_up_val;
		logic pull_down_val;
	} psc_pin_t;

	// Latched power-up configuration
	typedef struct packed {
		psc_iotype_t out_type;
		psc_edge_t edge_rate;
		psc_iotype_t in_type;
		psc_div_t div;
		logic [PSC_DRIVE_W-1:0] drive;
	} psc_cfg_t;

	localparam psc_cfg_t PSC_CFG_RST = '{PSC_IO_LVCMOS, PSC_EDGE_FAST, PSC_IO_LVCMOS, PSC_DIV_1, PSC_DRIVE_RST};

endpackage

/* File: core/psc_decoder.sv */
// Pin strap configuration decoder: power-up straps and continuously sampled pins
`timescale 1ns/100ps

module psc_decoder
	import psc_pkg::*;
#(
	parameter int NUM_OUTPUTS = 8
) (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst,
	// Power-up straps, each sensed with pull-up and pull-down probes
	input wire psc_pin_t output_type_strap,
	input wire psc_pin_t edge_rate_strap,
	input wire psc_pin_t input_type_strap,
	input wire psc_pin_t divide_strap,
	// Continuously sampled pins
	input wire psc_pin_t input_select_pin,
	input wire psc_pin_t output_enable_pin,
	// Decoded configuration
	output psc_cfg_t cfg,
	output logic cfg_valid,
	output logic [NUM_OUTPUTS-1:0] out_enable,
	output logic primary_clock_input_on,
	output logic secondary_clock_input_on,
	output psc_sel_t input_select_mode,
	output logic oe_pin_fault
);

	// ********************************
	// Three-level resolution
	// ********************************

	function automatic psc_level_t resolve(input psc_pin_t p);
		if (p.pull_up_val && p.pull_down_val) begin
			return PSC_LVL_HIGH;
		end else if (!p.pull_up_val && !p.pull_down_val) begin
			return PSC_LVL_LOW;
		end else begin
			// Follows whichever pull it sees: nothing drives it
			return PSC_LVL_OPEN;
		end
	endfunction

	// Shared decode for output and input types
	function automatic psc_iotype_t type_of(input psc_level_t l);
		case (l)
			PSC_LVL_LOW: return PSC_IO_LVDS;
			PSC_LVL_HIGH: return PSC_IO_HCSL;
			default: return PSC_IO_LVCMOS;
		endcase
	endfunction

	function automatic logic [PSC_DRIVE_W-1:0] drive_of(input psc_iotype_t t, input psc_edge_t e);
		return {t, e};
	endfunction

	// ********************************
	// Power-up capture
	// ********************************
	psc_state_t state_r;
	psc_cfg_t cfg_r;
	psc_level_t ot_lvl, er_lvl, it_lvl, dv_lvl;
	psc_iotype_t ot_dec;
	psc_edge_t er_dec;
	psc_div_t dv_dec;

	assign ot_lvl = resolve(output_type_strap);
	assign er_lvl = resolve(edge_rate_strap);
	assign it_lvl = resolve(input_type_strap);
	assign dv_lvl = resolve(divide_strap);

	assign ot_dec = type_of(ot_lvl);

	always_comb begin
		case (er_lvl)
			PSC_LVL_LOW: er_dec = PSC_EDGE_SLOW;
			PSC_LVL_HIGH: er_dec = PSC_EDGE_MEDIUM;
			default: er_dec = PSC_EDGE_FAST;
		endcase
	end

	always_comb begin
		case (dv_lvl)
			PSC_LVL_LOW: dv_dec = PSC_DIV_2;
			PSC_LVL_HIGH: dv_dec = PSC_DIV_4;
			default: dv_dec = PSC_DIV_1;
		endcase
	end

	// Sequence: one settle cycle after reset release, then sample once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= PSC_ST_RESET;
		end else begin
			case (state_r)
				PSC_ST_RESET: state_r <= PSC_ST_SAMPLE;
				PSC_ST_SAMPLE: state_r <= PSC_ST_RUN;
				PSC_ST_RUN: state_r <= PSC_ST_RUN;
				default: state_r <= PSC_ST_RESET;
			endcase
		end
	end

	// latched until reset
	// Straps are taken by a clock edge after release, never under reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_r <= PSC_CFG_RST;
		end else if (state_r == PSC_ST_SAMPLE) begin
			cfg_r.out_type <= ot_dec;
			cfg_r.edge_rate <= er_dec;
			cfg_r.in_type <= type_of(it_lvl);
			cfg_r.div <= dv_dec;
			cfg_r.drive <= drive_of(ot_dec, er_dec);
		end
	end

	assign cfg = cfg_r;
	assign cfg_valid = (state_r == PSC_ST_RUN);

	// ********************************
	// Live pins
	// ********************************
	// Select syncs reset to the open pattern, so the mode stays auto after release instead of
	// flashing primary-only for two cycles before the real pin level arrives
	localparam logic [1:0] SEL_SYNC_RST = 2'h2;
	logic [1:0] sel_s1_r, sel_s2_r, oe_s1_r, oe_s2_r;
	psc_level_t sel_lvl, oe_lvl;
	psc_sel_t sel_r;
	logic oe_r, oe_fault_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_s1_r <= SEL_SYNC_RST;
			sel_s2_r <= SEL_SYNC_RST;
			oe_s1_r <= 2'h0;
			oe_s2_r <= 2'h0;
		end else begin
			sel_s1_r <= input_select_pin;
			sel_s2_r <= sel_s1_r;
			oe_s1_r <= output_enable_pin;
			oe_s2_r <= oe_s1_r;
		end
	end

	assign sel_lvl = resolve(sel_s2_r);
	assign oe_lvl = resolve(oe_s2_r);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_r <= PSC_SEL_AUTO;
		end else begin
			case (sel_lvl)
				PSC_LVL_LOW: sel_r <= PSC_SEL_PRIMARY;
				PSC_LVL_HIGH: sel_r <= PSC_SEL_SECONDARY;
				default: sel_r <= PSC_SEL_AUTO;
			endcase
		end
	end

	// open held disabled
	// An open pin is reserved; outputs stay off and a fault is flagged
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oe_r <= 1'b0;
			oe_fault_r <= 1'b0;
		end else begin
			oe_r <= (oe_lvl == PSC_LVL_HIGH) && (state_r == PSC_ST_RUN);
			oe_fault_r <= (oe_lvl == PSC_LVL_OPEN);
		end
	end

	// Per-output enables, one copy per clock output
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_oe
			assign out_enable[gi] = oe_r;
		end
	endgenerate

	assign input_select_mode = sel_r;
	assign primary_clock_input_on = (sel_r != PSC_SEL_SECONDARY);
	assign secondary_clock_input_on = (sel_r != PSC_SEL_PRIMARY);
	assign oe_pin_fault = oe_fault_r;

	// ********************************
	// Checks
	// ********************************

	chk_strap_hold: assert property (@(posedge clk) disable iff (rst)
		(state_r == PSC_ST_RUN) |=> $stable(cfg_r)) else $error("configuration changed after capture");

	chk_capture_type: assert property (@(posedge clk) disable iff (rst)
		(state_r == PSC_ST_SAMPLE) |=> (cfg_r.out_type == $past(ot_dec))) else $error("output type not captured");

	chk_edge_slow: assert property (@(posedge clk) disable iff (rst)
		(state_r == PSC_ST_SAMPLE && er_lvl == PSC_LVL_LOW) |=> (cfg_r.edge_rate == PSC_EDGE_SLOW))
		else $error("low edge strap not slow");

	chk_div_open: assert property (@(posedge clk) disable iff (rst)
		(state_r == PSC_ST_SAMPLE && dv_lvl == PSC_LVL_OPEN) |=> (cfg_r.div == PSC_DIV_1))
		else $error("open divider strap not divide by one");

	chk_intype_high: assert property (@(posedge clk) disable iff (rst)
		(state_r == PSC_ST_SAMPLE && it_lvl == PSC_LVL_HIGH) |=> (cfg_r.in_type == PSC_IO_HCSL))
		else $error("high input strap not HCSL");

	chk_oe_low_off: assert property (@(posedge clk) disable iff (rst)
		(output_enable_pin == 2'h0) [*3] |=> (out_enable == '0)) else $error("outputs on while enable low");

	chk_oe_high_on: assert property (@(posedge clk) disable iff (rst)
		(cfg_valid && output_enable_pin == 2'h3) [*4] |-> (out_enable == '1)) else $error("outputs off while enable high");

	chk_sel_primary: assert property (@(posedge clk) disable iff (rst)
		(input_select_pin == 2'h0) [*4] |-> (primary_clock_input_on && !secondary_clock_input_on))
		else $error("low select did not pick primary only");

	chk_drive_pair: assert property (@(posedge clk) disable iff (rst)
		cfg_valid |-> (cfg_r.drive == {cfg_r.out_type, cfg_r.edge_rate})) else $error("drive code mismatch");

	chk_level_open: assert property (@(posedge clk) disable iff (rst)
		(oe_s2_r == 2'h2) |=> oe_pin_fault) else $error("open level not resolved");

	chk_valid_time: assert property (@(posedge clk) disable iff (rst)
		$rose(cfg_valid) |-> $past(state_r == PSC_ST_SAMPLE)) else $error("valid without capture");

endmodule

/* File: tb/psc_strap_model.sv */
// Board-side model: strap resistors and control logic that set the configuration pins
`timescale 1ns/100ps

module psc_strap_model
	import psc_pkg::*;
(
	// Requested level of each pin: out type, edge, in type, divide, select, enable
	input wire psc_level_t lvl [0:5],
	// Pins as the device probes them
	output psc_pin_t pin [0:5]
);

	// ********************************
	// Three-level pin drive
	// ********************************
	// three-state pin levels
	// An open pin has no driver, so the weak pull-up wins one probe and the pull-down the other
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			case (lvl[k])
				PSC_LVL_HIGH: pin[k] = '{1'b1, 1'b1};
				PSC_LVL_LOW: pin[k] = '{1'b0, 1'b0};
				default: pin[k] = '{1'b1, 1'b0};
			endcase
		end
	end

endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the pin strap configuration decoder
`timescale 1ns/100ps

module testbench;
	import psc_pkg::*;

	logic clk;
	logic rst;
	psc_level_t lvl [0:5];
	psc_pin_t pin [0:5];
	psc_cfg_t cfg;
	logic cfg_valid;
	logic [7:0] out_enable;
	logic primary_clock_input_on;
	logic secondary_clock_input_on;
	psc_sel_t input_select_mode;
	logic oe_pin_fault;
	int n_errors;
	int checked;
	psc_cfg_t exp_cfg;
	// Expected codes indexed by level: low, high, open
	psc_iotype_t exp_type [0:2] = '{PSC_IO_LVDS, PSC_IO_HCSL, PSC_IO_LVCMOS};
	psc_edge_t exp_edge [0:2] = '{PSC_EDGE_SLOW, PSC_EDGE_MEDIUM, PSC_EDGE_FAST};
	psc_div_t exp_div [0:2] = '{PSC_DIV_2, PSC_DIV_4, PSC_DIV_1};
	psc_sel_t exp_sel [0:2] = '{PSC_SEL_PRIMARY, PSC_SEL_SECONDARY, PSC_SEL_AUTO};

	psc_strap_model psc_strap_model_i (.lvl(lvl), .pin(pin));

	psc_decoder #(.NUM_OUTPUTS(8)) psc_decoder_i (
		.clk(clk), .rst(rst),
		.output_type_strap(pin[0]), .edge_rate_strap(pin[1]),
		.input_type_strap(pin[2]), .divide_strap(pin[3]),
		.input_select_pin(pin[4]), .output_enable_pin(pin[5]),
		.cfg(cfg), .cfg_valid(cfg_valid), .out_enable(out_enable),
		.primary_clock_input_on(primary_clock_input_on),
		.secondary_clock_input_on(secondary_clock_input_on),
		.input_select_mode(input_select_mode), .oe_pin_fault(oe_pin_fault)
	);

	// Free-running 250 MHz clock
	always #2 clk = ~clk;

	// ********************************
	// Compare and timing tasks
	// ********************************
	task automatic cmp_cfg(input psc_cfg_t got, input psc_cfg_t exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_v(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Stimulus lands one nanosecond after the edge, clear of sampling
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic final_report();
		$display("errors=%0d checks=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Straps set, then a power-on reset pulse and the two-edge capture
	task automatic power_up(input int a, input int b, input int c, input int d);
		lvl[0] = psc_level_t'(a);
		lvl[1] = psc_level_t'(b);
		lvl[2] = psc_level_t'(c);
		lvl[3] = psc_level_t'(d);
		rst = 1'b1;
		step(1);
		cmp_cfg(cfg, PSC_CFG_RST);
		cmp_v({out_enable[0], cfg_valid, 4'h0, input_select_mode}, {2'h0, 4'h0, PSC_SEL_AUTO});
		rst = 1'b0;
		step(1);
		cmp_v({7'h0, cfg_valid}, 8'h00);
		step(1);
		exp_cfg = '{exp_type[a], exp_edge[b], exp_type[c], exp_div[d], {exp_type[a], exp_edge[b]}};
		cmp_v({7'h0, cfg_valid}, 8'h01);
		cmp_v(out_enable, 8'h00);
		cmp_cfg(cfg, exp_cfg);
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		n_errors = 0;
		checked = 0;
		for (int k = 0; k < 4; k++) lvl[k] = PSC_LVL_OPEN;
		lvl[4] = PSC_LVL_OPEN;
		// enable pin held at a valid level
		lvl[5] = PSC_LVL_HIGH;
		step(4);
		// Every strap sees low, high and open across the three power-ups
		for (int i = 0; i < 3; i++) begin
			power_up(i, (i + 1) % 3, (i + 2) % 3, (i + 1) % 3);
		end
		// Straps moved after capture must leave the latched set alone
		for (int k = 0; k < 4; k++) lvl[k] = PSC_LVL_LOW;
		step(3);
		cmp_cfg(cfg, exp_cfg);
		// Live pins: low, high, open on both, three edges to act
		for (int j = 0; j < 3; j++) begin
			lvl[4] = psc_level_t'(j);
			lvl[5] = psc_level_t'(j);
			step(2);
			cmp_v(out_enable, (j == 0) ? 8'hFF : ((j == 1) ? 8'h00 : 8'hFF));
			step(1);
			cmp_v(out_enable, (j == 1) ? 8'hFF : 8'h00);
			cmp_v({7'h0, oe_pin_fault}, {7'h0, j == 2});
			cmp_v({6'h0, input_select_mode}, {6'h0, exp_sel[j]});
			cmp_v({6'h0, primary_clock_input_on, secondary_clock_input_on}, {6'h0, j != 1, j != 0});
			// Hold each level a while longer so the held-level checks in the design see it
			step(2);
		end
		final_report();
	end

endmodule
